// ### sdr_core.sv
// 576-bit storage array, one write port and one read port, shaped by width
`timescale 1ns/1ps
module sdr_core (
   input  wire logic i_clk,
   sdr_mem_if.core   mem_port
);
   logic        mem [sdr_pkg::MEM_BITS];
   logic [4:0]  width;
   logic [9:0]  wr_base;
   logic [9:0]  rd_base;

   assign width   = sdr_pkg::sdr_width(mem_port.shape);
   assign wr_base = 10'(mem_port.wr_addr * width);
   assign rd_base = 10'(mem_port.rd_addr * width);

   // per-bit write with byte lanes; lane 1 is the upper half of 16/18 widths
   always_ff @(posedge i_clk) begin
      if (mem_port.wr_en) begin
         for (int j = 0; j < sdr_pkg::DATA_W; j++) begin
            if (5'(j) < width) begin
               if ((width >= 5'h10 && 5'(j) >= (width >> 1)) ? mem_port.wr_be[1]
                                                             : mem_port.wr_be[0]) begin
                  mem[10'(wr_base + 10'(j))] <= mem_port.wr_data[j];
               end
            end
         end
      end
   end

   // read port sees the array before this edge's write, giving old data
   always_comb begin
      mem_port.rd_data = 18'h0;
      for (int j = 0; j < sdr_pkg::DATA_W; j++) begin
         if (5'(j) < width) begin
            mem_port.rd_data[j] = mem[10'(rd_base + 10'(j))];
         end
      end
   end
endmodule // sdr_core

// ### sdr_fabric.sv
// fabric-side model driving write, read, enable and clear inputs of the ram block
`timescale 1ns/1ps
module sdr_fabric (
   input  wire logic        i_clk,
   input  wire logic [17:0] i_rd_data,
   output logic             o_clk_en_0,
   output logic             o_clk_en_1,
   output logic             o_wr_en,
   output logic [9:0]       o_wr_addr,
   output logic [17:0]      o_wr_data,
   output logic [1:0]       o_wr_be,
   output logic             o_rd_en,
   output logic [9:0]       o_rd_addr,
   output logic             o_in_clr,
   output logic             o_out_clr
);
   initial begin
      o_clk_en_0 = 1'b1;
      o_clk_en_1 = 1'b0;
      {o_wr_en, o_wr_addr, o_wr_data, o_wr_be} = '0;
      {o_rd_en, o_rd_addr, o_in_clr, o_out_clr} = '0;
   end
   // second enable toggles; unselected, it must not disturb anything
   always @(posedge i_clk) o_clk_en_1 <= ~o_clk_en_1;
   task automatic wr(input logic [9:0] a, input logic [17:0] d, input logic [1:0] be);
      @(posedge i_clk);
      o_wr_en <= 1'b1;
      o_wr_addr <= a;
      o_wr_data <= d;
      o_wr_be <= be;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      // released lines show junk, not the last word
      o_wr_data <= ~d;
      o_wr_addr <= ~a;
   endtask
   task automatic rd(input logic [9:0] a, input bit byp, output logic [17:0] d);
      @(posedge i_clk);
      o_rd_en <= 1'b1;
      o_rd_addr <= a;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      o_rd_addr <= ~a;
      if (!byp) @(posedge i_clk);
      #1 d = i_rd_data;
   endtask
   task automatic clr(input bit o, output logic [17:0] d);
      @(posedge i_clk);
      if (o) o_out_clr <= 1'b1;
      else o_in_clr <= 1'b1;
      #1 d = i_rd_data;
      @(posedge i_clk);
      o_out_clr <= 1'b0;
      o_in_clr <= 1'b0;
   endtask
endmodule // sdr_fabric

// ### sdr_mem_if.sv
// write and read port bundle between the control logic and the storage array
`timescale 1ns/1ps
interface sdr_mem_if;
   logic [2:0]  shape;
   logic        wr_en;
   logic [9:0]  wr_addr;
   logic [17:0] wr_data;
   logic [1:0]  wr_be;
   logic [9:0]  rd_addr;
   logic [17:0] rd_data;

   modport ctrl (output shape, output wr_en, output wr_addr, output wr_data,
                 output wr_be, output rd_addr, input rd_data);
   modport core (input shape, input wr_en, input wr_addr, input wr_data,
                 input wr_be, input rd_addr, output rd_data);
endinterface

// ### sdr_pkg.sv
// shared constants, register map and shape helpers for the small dual-port ram block
package sdr_pkg;
   localparam int unsigned MEM_BITS   = 576;
   localparam int unsigned DATA_W     = 18;
   localparam int unsigned ADDR_W     = 10;
   localparam int unsigned LANES      = 2;

   // apb register byte offsets
   localparam logic [11:0] OFF_CTRL      = 12'h000;
   localparam logic [11:0] OFF_STATUS    = 12'h004;
   localparam logic [11:0] OFF_INIT_ADDR = 12'h008;
   localparam logic [11:0] OFF_INIT_DATA = 12'h00c;

   // control field positions
   localparam int unsigned CTRL_MODE_LSB  = 0;
   localparam int unsigned CTRL_SHAPE_LSB = 3;
   localparam int unsigned CTRL_WCLK      = 6;
   localparam int unsigned CTRL_RACLK     = 7;
   localparam int unsigned CTRL_RECLK     = 8;
   localparam int unsigned CTRL_OCLK      = 9;
   localparam int unsigned CTRL_BYPASS    = 10;
   localparam int unsigned CTRL_RDW_OLD   = 11;
   localparam int unsigned CTRL_W         = 12;
   localparam logic [11:0] CTRL_RESET     = 12'h800;

   // status field positions
   localparam int unsigned STAT_EMPTY     = 0;
   localparam int unsigned STAT_FULL      = 1;
   localparam int unsigned STAT_COUNT_LSB = 2;

   // operating modes
   localparam logic [2:0] MODE_SDP   = 3'h0;
   localparam logic [2:0] MODE_SP    = 3'h1;
   localparam logic [2:0] MODE_FIFO  = 3'h2;
   localparam logic [2:0] MODE_ROM   = 3'h3;
   localparam logic [2:0] MODE_SHIFT = 3'h4;

   // shapes, depth x width
   localparam logic [2:0] SHAPE_512X1 = 3'h0;
   localparam logic [2:0] SHAPE_256X2 = 3'h1;
   localparam logic [2:0] SHAPE_128X4 = 3'h2;
   localparam logic [2:0] SHAPE_64X8  = 3'h3;
   localparam logic [2:0] SHAPE_64X9  = 3'h4;
   localparam logic [2:0] SHAPE_32X16 = 3'h5;
   localparam logic [2:0] SHAPE_32X18 = 3'h6;

   function automatic logic [4:0] sdr_width(input logic [2:0] shape);
      case (shape)
         SHAPE_512X1: sdr_width = 5'h01;
         SHAPE_256X2: sdr_width = 5'h02;
         SHAPE_128X4: sdr_width = 5'h04;
         SHAPE_64X8:  sdr_width = 5'h08;
         SHAPE_64X9:  sdr_width = 5'h09;
         SHAPE_32X16: sdr_width = 5'h10;
         default:     sdr_width = 5'h12;
      endcase
   endfunction

   function automatic logic [9:0] sdr_depth(input logic [2:0] shape);
      case (shape)
         SHAPE_512X1: sdr_depth = 10'h200;
         SHAPE_256X2: sdr_depth = 10'h100;
         SHAPE_128X4: sdr_depth = 10'h080;
         SHAPE_64X8:  sdr_depth = 10'h040;
         SHAPE_64X9:  sdr_depth = 10'h040;
         default:     sdr_depth = 10'h020;
      endcase
   endfunction

   // next address with wrap at the shape's depth
   function automatic logic [9:0] sdr_inc(input logic [9:0] a, input logic [2:0] shape);
      sdr_inc = (a + 10'h001 >= sdr_depth(shape)) ? 10'h000 : a + 10'h001;
   endfunction

   // data bits of the current width
   function automatic logic [17:0] sdr_mask(input logic [2:0] shape);
      sdr_mask = 18'(({18'h0, 1'b1} << sdr_width(shape)) - 19'h1);
   endfunction
endpackage

// ### sdr_ram.sv
// small simple dual-port ram block: apb configuration, port registers, modes
//
// Functional notes
// - 576 bits, shapes 512x1 through 32x18
// - one write port, one read port only
// - modes: dual-port, single-port, fifo, rom, shift
// - ram and rom contents preloadable before use
// - write enable, data, address share one clock
// - read address (fifo mode: the enable's clock), enable, output pick either clock
// - only output register may be bypassed
// - input clear shows at output next edge
// - output clear shows on output immediately
`timescale 1ns/1ps
module sdr_ram (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_clk_en_0,
   input  wire logic        i_clk_en_1,
   input  wire logic        i_wr_en,
   input  wire logic [9:0]  i_wr_addr,
   input  wire logic [17:0] i_wr_data,
   input  wire logic [1:0]  i_wr_be,
   input  wire logic        i_rd_en,
   input  wire logic [9:0]  i_rd_addr,
   input  wire logic        i_in_clr,
   input  wire logic        i_out_clr,
   output logic      [17:0] o_rd_data,
   output logic             o_fifo_empty,
   output logic             o_fifo_full
);
   sdr_mem_if mem_port ();

   logic [11:0] ctrl_reg;
   logic [9:0]  init_addr_reg;
   logic        wr_en_reg;
   logic [9:0]  wr_addr_reg;
   logic [17:0] wr_data_reg;
   logic [1:0]  wr_be_reg;
   logic        rd_en_reg;
   logic [9:0]  rd_addr_reg;
   logic [17:0] out_reg;
   logic [9:0]  fifo_wr_ptr_reg;
   logic [9:0]  fifo_rd_ptr_reg;
   logic [9:0]  fifo_count_reg;
   logic [9:0]  shift_ptr_reg;
   logic [2:0]  mode;
   logic [2:0]  shape;
   logic        w_ce;
   logic        ra_ce;
   logic        re_ce;
   logic        o_ce;
   logic        push;
   logic        pop;
   logic        shift_step;
   logic        init_wr;
   logic        apb_setup;
   logic        apb_access;
   logic        addr_ok;
   logic        collide;
   logic [17:0] raw_data;

   assign mode  = ctrl_reg[sdr_pkg::CTRL_MODE_LSB +: 3];
   assign shape = ctrl_reg[sdr_pkg::CTRL_SHAPE_LSB +: 3];

   // each register group picks one of the two block rates
   assign w_ce  = ctrl_reg[sdr_pkg::CTRL_WCLK]  ? i_clk_en_1 : i_clk_en_0;
   assign ra_ce = ctrl_reg[sdr_pkg::CTRL_RACLK] ? i_clk_en_1 : i_clk_en_0;
   assign re_ce = ctrl_reg[sdr_pkg::CTRL_RECLK] ? i_clk_en_1 : i_clk_en_0;
   assign o_ce  = ctrl_reg[sdr_pkg::CTRL_OCLK]  ? i_clk_en_1 : i_clk_en_0;

   assign o_fifo_empty = (fifo_count_reg == 10'h000);
   assign o_fifo_full  = (fifo_count_reg == sdr_pkg::sdr_depth(shape));

   assign push = (mode == sdr_pkg::MODE_FIFO) && w_ce && i_wr_en && !o_fifo_full;
   assign pop  = (mode == sdr_pkg::MODE_FIFO) && re_ce && i_rd_en && !o_fifo_empty;
   assign shift_step = (mode == sdr_pkg::MODE_SHIFT) && w_ce && i_wr_en;

   // apb: zero wait states, read data captured during setup
   assign apb_setup  = i_psel && !i_penable;
   assign apb_access = i_psel && i_penable;
   assign addr_ok    = (i_paddr == sdr_pkg::OFF_CTRL) || (i_paddr == sdr_pkg::OFF_STATUS) ||
                       (i_paddr == sdr_pkg::OFF_INIT_ADDR) || (i_paddr == sdr_pkg::OFF_INIT_DATA);
   assign o_pready   = 1'b1;
   assign o_pslverr  = apb_access && !addr_ok;
   assign init_wr    = apb_access && i_pwrite && (i_paddr == sdr_pkg::OFF_INIT_DATA);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_reg <= sdr_pkg::CTRL_RESET;
      end else if (apb_access && i_pwrite && i_paddr == sdr_pkg::OFF_CTRL) begin
         ctrl_reg <= i_pwdata[sdr_pkg::CTRL_W-1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         init_addr_reg <= 10'h000;
      end else if (apb_access && i_pwrite && i_paddr == sdr_pkg::OFF_INIT_ADDR) begin
         init_addr_reg <= i_pwdata[9:0];
      end else if (init_wr) begin
         init_addr_reg <= sdr_pkg::sdr_inc(init_addr_reg, shape);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_prdata <= 32'h0;
      end else if (apb_setup && !i_pwrite) begin
         case (i_paddr)
            sdr_pkg::OFF_CTRL:      o_prdata <= {20'h0, ctrl_reg};
            sdr_pkg::OFF_STATUS:    o_prdata <= {20'h0, fifo_count_reg, o_fifo_full,
                                                 o_fifo_empty};
            sdr_pkg::OFF_INIT_ADDR: o_prdata <= {22'h0, init_addr_reg};
            default:                o_prdata <= 32'h0;
         endcase
      end
   end

   // write-side input registers; these can never be bypassed
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_en_reg   <= 1'b0;
         wr_addr_reg <= 10'h000;
         wr_data_reg <= 18'h0;
         wr_be_reg   <= 2'h0;
      end else if (i_in_clr) begin
         wr_en_reg   <= 1'b0;
         wr_addr_reg <= 10'h000;
         wr_data_reg <= 18'h0;
         wr_be_reg   <= 2'h0;
      end else if (init_wr) begin
         // preload takes the write port; a fabric write in this cycle is dropped
         wr_en_reg   <= 1'b1;
         wr_addr_reg <= init_addr_reg;
         wr_data_reg <= i_pwdata[17:0];
         wr_be_reg   <= 2'h3;
      end else if (w_ce) begin
         case (mode)
            sdr_pkg::MODE_ROM:   wr_en_reg <= 1'b0;
            sdr_pkg::MODE_FIFO:  wr_en_reg <= push;
            default:             wr_en_reg <= i_wr_en;
         endcase
         case (mode)
            sdr_pkg::MODE_FIFO:  wr_addr_reg <= fifo_wr_ptr_reg;
            sdr_pkg::MODE_SHIFT: wr_addr_reg <= shift_ptr_reg;
            default:             wr_addr_reg <= i_wr_addr;
         endcase
         wr_data_reg <= i_wr_data;
         wr_be_reg   <= (mode == sdr_pkg::MODE_FIFO || mode == sdr_pkg::MODE_SHIFT) ? 2'h3
                                                                                   : i_wr_be;
      end else begin
         wr_en_reg <= 1'b0;
      end
   end

   // read address register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_addr_reg <= 10'h000;
      end else if (i_in_clr) begin
         rd_addr_reg <= 10'h000;
      end else if (mode == sdr_pkg::MODE_FIFO) begin
         if (pop) begin
            rd_addr_reg <= fifo_rd_ptr_reg;
         end
      end else if (ra_ce) begin
         case (mode)
            sdr_pkg::MODE_SP:    rd_addr_reg <= i_wr_addr;
            sdr_pkg::MODE_SHIFT: rd_addr_reg <= shift_ptr_reg;
            default:             rd_addr_reg <= i_rd_addr;
         endcase
      end
   end

   // read enable register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_en_reg <= 1'b0;
      end else if (i_in_clr) begin
         rd_en_reg <= 1'b0;
      end else if (re_ce) begin
         case (mode)
            sdr_pkg::MODE_FIFO:  rd_en_reg <= pop;
            sdr_pkg::MODE_SHIFT: rd_en_reg <= i_wr_en;
            default:             rd_en_reg <= i_rd_en;
         endcase
      end
   end

   // fifo pointers and fill level; a shape change does not rescale them
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fifo_wr_ptr_reg <= 10'h000;
         fifo_rd_ptr_reg <= 10'h000;
         fifo_count_reg  <= 10'h000;
      end else if (i_in_clr) begin
         fifo_wr_ptr_reg <= 10'h000;
         fifo_rd_ptr_reg <= 10'h000;
         fifo_count_reg  <= 10'h000;
      end else begin
         if (push) begin
            fifo_wr_ptr_reg <= sdr_pkg::sdr_inc(fifo_wr_ptr_reg, shape);
         end
         if (pop) begin
            fifo_rd_ptr_reg <= sdr_pkg::sdr_inc(fifo_rd_ptr_reg, shape);
         end
         if (push && !pop) begin
            fifo_count_reg <= fifo_count_reg + 10'h001;
         end else if (pop && !push) begin
            fifo_count_reg <= fifo_count_reg - 10'h001;
         end
      end
   end

   // shift register: read the oldest entry where the new one lands
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shift_ptr_reg <= 10'h000;
      end else if (i_in_clr) begin
         shift_ptr_reg <= 10'h000;
      end else if (shift_step) begin
         shift_ptr_reg <= sdr_pkg::sdr_inc(shift_ptr_reg, shape);
      end
   end

   assign mem_port.shape   = shape;
   assign mem_port.wr_en   = wr_en_reg;
   assign mem_port.wr_addr = wr_addr_reg;
   assign mem_port.wr_data = wr_data_reg;
   assign mem_port.wr_be   = wr_be_reg;
   assign mem_port.rd_addr = rd_addr_reg;

   sdr_core u_core (
      .i_clk    (i_clk),
      .mem_port (mem_port)
   );

   // collision: "unknown" setting forwards the write data; shift mode needs old data
   assign collide  = wr_en_reg && rd_en_reg && (wr_addr_reg == rd_addr_reg);
   assign raw_data = (collide && !ctrl_reg[sdr_pkg::CTRL_RDW_OLD] &&
                      mode != sdr_pkg::MODE_SHIFT)
                   ? (wr_data_reg & sdr_pkg::sdr_mask(shape)) : mem_port.rd_data;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         out_reg <= 18'h0;
      end else if (i_out_clr) begin
         out_reg <= 18'h0;
      end else if (o_ce && rd_en_reg) begin
         out_reg <= raw_data;
      end
   end

   // output clear masks at once, without waiting for an edge
   assign o_rd_data = i_out_clr ? 18'h0 :
                      (ctrl_reg[sdr_pkg::CTRL_BYPASS] ? raw_data : out_reg);
endmodule // sdr_ram

// ### sdr_ram_asserts.sv
// concurrent checks on the top ports of the small dual-port ram block
`timescale 1ns/1ps
module sdr_ram_asserts (
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic [11:0] i_paddr,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_wr_en,
   input wire logic        i_rd_en,
   input wire logic        i_in_clr,
   input wire logic        i_out_clr,
   input wire logic [17:0] o_rd_data,
   input wire logic        o_fifo_empty,
   input wire logic        o_fifo_full
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // four mapped words at the bottom of the space
   wire unmapped = (i_paddr[11:4] != 8'h00) || (i_paddr[1:0] != 2'h0);
   sequence s_setup;
      i_psel && !i_penable;
   endsequence
   sequence s_access;
      s_setup ##1 (i_psel && i_penable);
   endsequence
   a_ready_access: assert property (s_access |-> o_pready) else $error("no ready in access");
   a_slverr_map: assert property (s_access |-> o_pslverr == unmapped) else $error("bad slverr");
   a_slverr_idle: assert property (!(i_psel && i_penable) |-> !o_pslverr)
      else $error("slverr outside access");
   a_reset_clear: assert property ($rose(i_reset_n) |->
      o_rd_data == 18'h0 && o_fifo_empty && !o_fifo_full)
      else $error("outputs not cleared by reset");
   a_out_clr_zero: assert property (i_out_clr |-> o_rd_data == 18'h0)
      else $error("output clear not immediate");
   a_flags_excl: assert property (!(o_fifo_empty && o_fifo_full))
      else $error("empty and full together");
   a_full_holds: assert property (o_fifo_full && !i_rd_en && !i_in_clr |=> o_fifo_full)
      else $error("full dropped without pop");
   a_empty_holds: assert property (o_fifo_empty && !i_wr_en |=> o_fifo_empty)
      else $error("empty dropped without push");
   a_full_cause: assert property ($rose(o_fifo_full) |-> $past(i_wr_en))
      else $error("full without push");
   a_empty_cause: assert property ($rose(o_fifo_empty) |->
      $past(i_rd_en) || $past(i_in_clr)) else $error("empty without pop");
   a_in_clr_empty: assert property (i_in_clr |=> o_fifo_empty)
      else $error("input clear kept count");
endmodule // sdr_ram_asserts

bind sdr_ram sdr_ram_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
   .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_in_clr(i_in_clr), .i_out_clr(i_out_clr),
   .o_rd_data(o_rd_data), .o_fifo_empty(o_fifo_empty), .o_fifo_full(o_fifo_full));

// ### small_dual_port_ram_block_tb.sv
// self-checking bench for the small dual-port ram block
`timescale 1ns/1ps
module small_dual_port_ram_block_tb;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        ce0, ce1, wr_en, rd_en, in_clr, out_clr, empty, full;
   logic [9:0]  wr_addr, rd_addr, a;
   logic [17:0] wr_data, rd_data, d, q, mem [32], fq [33];
   logic [1:0]  wr_be, be;
   integer      seed, n_mismatch, check_count, cyc;
   sdr_ram dut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_clk_en_0(ce0), .i_clk_en_1(ce1),
      .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_wr_be(wr_be),
      .i_rd_en(rd_en), .i_rd_addr(rd_addr), .i_in_clr(in_clr), .i_out_clr(out_clr),
      .o_rd_data(rd_data), .o_fifo_empty(empty), .o_fifo_full(full));
   sdr_fabric fab (.i_clk(clk), .i_rd_data(rd_data), .o_clk_en_0(ce0), .o_clk_en_1(ce1),
      .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_wr_be(wr_be),
      .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_in_clr(in_clr), .o_out_clr(out_clr));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic summarize;
      $display("mismatches %0d of %0d checks", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count = check_count + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // byte lanes of the 18-bit shape are 9 bits each
   function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n, logic [1:0] b);
      return {b[1] ? n[17:9] : o[17:9], b[0] ? n[8:0] : o[8:0]};
   endfunction
   initial begin
      {seed, n_mismatch, check_count, cyc} = {32'd33, 96'd0};
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk({empty, full, rd_data}, {2'h2, 18'h0});
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h800);
      apb(1'b0, 12'h010, 32'h0);
      chk(r, 32'h0);
      for (int m = 0; m < 5; m++) begin
         apb(1'b1, 12'h000, 32'h830 | m);
         apb(1'b0, 12'h000, 32'h0);
         chk(r, 32'h830 | m);
      end
      apb(1'b1, 12'h000, 32'h833);
      apb(1'b1, 12'h008, 32'h0);
      for (int i = 0; i < 32; i++) begin
         mem[i] = 18'($random(seed));
         apb(1'b1, 12'h00c, {14'h0, mem[i]});
      end
      apb(1'b0, 12'h008, 32'h0);
      chk(r, 32'h0);
      fab.wr(10'h0, ~mem[0], 2'h3); // ROM ignores fabric writes
      for (int i = 0; i < 32; i++) begin
         fab.rd(10'(i), 1'b0, d);
         chk(d, mem[i]);
      end
      apb(1'b1, 12'h000, 32'h830);
      for (int i = 0; i < 24; i++) begin
         a = 10'($random(seed)) & 10'h01f;
         d = 18'($random(seed));
         be = 2'($random(seed));
         fab.wr(a, d, be);
         mem[a] = merge(mem[a], d, be);
      end
      fab.wr(10'h5, 18'h2aaaa, 2'h3);
      mem[5] = 18'h2aaaa;
      for (int i = 0; i < 32; i++) begin
         fab.rd(10'(i), 1'b0, d);
         chk(d, mem[i]);
      end
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 12'h000, k ? 32'h830 : 32'h030);
         d = 18'($random(seed));
         fork
            fab.wr(10'h7, d, 2'h3);
            fab.rd(10'h7, 1'b0, q);
         join
         chk(q, k ? mem[7] : d);
         mem[7] = d;
      end
      fab.rd(10'h5, 1'b0, d);
      fab.clr(1'b1, d);
      chk(d, 18'h0);
      #1 chk(rd_data, 18'h0);
      apb(1'b1, 12'h000, 32'hc30);
      fab.rd(10'h5, 1'b1, d);
      chk(d, mem[5]);
      apb(1'b1, 12'h000, 32'h832);
      fab.clr(1'b0, d);
      #1 chk(empty, 1'b1);
      for (int i = 0; i < 33; i++) begin
         fq[i] = 18'($random(seed));
         fab.wr(10'h0, fq[i], 2'h3);
      end
      apb(1'b0, 12'h004, 32'h0);
      chk(r, 32'h82);
      chk({full, empty}, 2'h2);
      for (int i = 0; i < 32; i++) begin
         fab.rd(10'h0, 1'b0, d);
         chk(d, fq[i]);
      end
      chk(empty, 1'b1);
      // shift mode: each step returns the word stored 32 steps earlier
      apb(1'b1, 12'h000, 32'h834);
      for (int i = 0; i < 32; i++) begin
         mem[i] = fq[i];
      end
      for (int i = 0; i < 34; i++) begin
         d = 18'($random(seed));
         fab.wr(10'h3ff, d, 2'h0);
         @(posedge clk);
         #1 chk(rd_data, mem[i % 32]);
         mem[i % 32] = d;
      end
      // single-port: read address follows the write address, old data on collision
      apb(1'b1, 12'h000, 32'h831);
      for (int k = 0; k < 2; k++) begin
         d = 18'($random(seed));
         fork
            fab.wr(10'h9, d, 2'h3);
            fab.rd(10'h8, 1'b0, q);
         join
         chk(q, mem[9]);
         mem[9] = d;
      end
      // reset in mid-run brings back the power-up state
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      #1 chk({empty, full, rd_data}, {2'h2, 18'h0});
      apb(1'b0, 12'h000, 32'h0);
      chk(r, 32'h800);
      summarize();
   end
endmodule // small_dual_port_ram_block_tb
